//--- src/adccfg_top.sv
// Summary of operation
// - Differential mode pairs inputs 0-1, 2-3 up to 14-15: eight channels.
// - Single-ended mode pairs each of 16 inputs with the common input.
// - Unipolar output is straight binary, zero to all ones.
// - Result is 24 bits; unipolar code is 2^24 times scaled input over ref.
// - Bipolar output is offset binary; zero input gives midscale.
// - Each setup holds a reference select field in bits 5 to 4.
// - Reference select resets to the external reference.
// - Internal reference is off at reset, drives its pin once enabled.
// - Internal reference enable is bit 15 of the mode register.
// - Master clock comes from oscillator, crystal or external clock.
// - Clock select field is bits 3 to 2 of the mode register.
// - Clock select resets to the internal oscillator.
// - The 16 MHz oscillator is divided down to a 2 MHz master clock.
// - Crystal mode divides the 16 MHz crystal to 2 MHz automatically.
// - Output data rate is derived from and scales with master clock.
// - When selected, the oscillator clock is driven on the shared pin.
// - External clock mode takes the shared pin as master clock.
// - Enabled channels convert in order, lowest to highest, then wrap.
`default_nettype none
module adccfg_top #(
  parameter int CONV_TICKS = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Clock sources and shared clock pin
  input wire logic osc_clk_in,
  input wire logic crystal_input_pin_in,
  input wire logic crystal_or_clock_io_pin_in,
  output logic crystal_or_clock_io_pin_out,
  output logic crystal_or_clock_io_pin_oe_b_out,
  output logic master_clock_out,
  // Conversion path
  input wire logic signed [24:0] sample_in,
  output logic [3:0] mux_pos_out,
  output logic [4:0] mux_neg_out,
  output logic [1:0] reference_source_select_out,
  output logic reference_output_pin_en_out,
  output logic conv_done_out
);
  localparam int NS = adccfg_pkg::NUM_SETUPS;

  // Next enabled channel above cur, else lowest enabled, else cur
  function automatic logic [3:0] next_ch(input logic [3:0] cur,
                                         input logic [15:0] en);
    logic [3:0] lo;
    logic [3:0] hi;
    logic fhi;
    logic flo;
    lo = cur;
    hi = cur;
    fhi = 1'b0;
    flo = 1'b0;
    for (int i = adccfg_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (en[i]) begin
        lo = 4'(i);
        flo = 1'b1;
        if (4'(i) > cur) begin
          hi = 4'(i);
          fhi = 1'b1;
        end
      end
    end
    return fhi ? hi : (flo ? lo : cur);
  endfunction : next_ch

  // Registers
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic ref_en_ff, se_ff;
  logic [1:0] clksel_ff;
  logic [15:0] chen_ff;
  logic [1:0] refsel_ff [NS];
  logic bip_ff [NS];
  logic [3:0] cur_ff;
  logic [23:0] data_ff;
  logic ready_ff;
  logic [15:0] tcnt_ff;
  logic [2:0] sync1_ff, sync2_ff, prev_ff;
  logic [3:0] mux_pos_ff;
  logic [4:0] mux_neg_ff;
  logic [1:0] active_ref_ff;
  logic ref_drive_ff, mclk_ff, io_out_ff, io_oe_b_ff, conv_ff;

  // Bus decode
  logic req, acc, wr_acc, rd_acc;
  logic sel_mode, sel_chen, sel_stat, sel_data, sel_setup;
  logic [2:0] sidx;
  logic [31:0] mode_word, stat_word, setup_word, nxt_rdata;

  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~waitreq_ff;
  assign wr_acc = acc & avs_write_in;
  assign rd_acc = acc & avs_read_in;
  assign sel_mode = avs_address_in == adccfg_pkg::OFF_MODE;
  assign sel_chen = avs_address_in == adccfg_pkg::OFF_CHEN;
  assign sel_stat = avs_address_in == adccfg_pkg::OFF_STAT;
  assign sel_data = avs_address_in == adccfg_pkg::OFF_DATA;
  assign sel_setup = avs_address_in[5] & (avs_address_in[1:0] == 2'h0);
  assign sidx = avs_address_in[4:2];

  assign mode_word = (32'(ref_en_ff) << adccfg_pkg::MODE_REFEN_BIT) |
                     (32'(se_ff) << adccfg_pkg::MODE_SE_BIT) |
                     (32'(clksel_ff) << adccfg_pkg::MODE_CLKSEL_LSB);
  assign stat_word = 32'(cur_ff) |
                     (32'(ready_ff) << adccfg_pkg::STAT_RDY_BIT) |
                     (32'(active_ref_ff) << adccfg_pkg::STAT_REF_LSB) |
                     (32'(mclk_ff) << adccfg_pkg::STAT_MCLK_BIT);
  assign setup_word = (32'(refsel_ff[sidx]) << adccfg_pkg::SETUP_REFSEL_LSB)
                    | (32'(bip_ff[sidx]) << adccfg_pkg::SETUP_BIP_BIT);
  // Unmapped offsets read as zero and ignore writes
  assign nxt_rdata = sel_mode ? mode_word :
                     sel_chen ? 32'(chen_ff) :
                     sel_stat ? stat_word :
                     sel_data ? 32'(data_ff) :
                     sel_setup ? setup_word : 32'h00000000;

  // One wait cycle per access, so read data is set up before the ack
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      waitreq_ff <= ~(req & waitreq_ff);
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_en_ff <= 1'b0;
      se_ff <= 1'b0;
      clksel_ff <= adccfg_pkg::CLKSEL_RST;
      chen_ff <= adccfg_pkg::CHEN_RST;
    end else if (wr_acc & sel_mode) begin
      ref_en_ff <= avs_writedata_in[adccfg_pkg::MODE_REFEN_BIT];
      se_ff <= avs_writedata_in[adccfg_pkg::MODE_SE_BIT];
      clksel_ff <=
        avs_writedata_in[adccfg_pkg::MODE_CLKSEL_LSB +: 2];
    end else if (wr_acc & sel_chen) begin
      chen_ff <= avs_writedata_in[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NS; i++) begin
        refsel_ff[i] <= adccfg_pkg::REFSEL_RST;
        bip_ff[i] <= adccfg_pkg::SETUP_BIP_RST;
      end
    end else if (wr_acc & sel_setup) begin
      refsel_ff[sidx] <=
        avs_writedata_in[adccfg_pkg::SETUP_REFSEL_LSB +: 2];
      bip_ff[sidx] <= avs_writedata_in[adccfg_pkg::SETUP_BIP_BIT];
    end
  end

  // Clock sources: bit 0 oscillator, 1 crystal, 2 shared pin.
  // Sampled on clk_in, so sources must run below half of clk_in.
  logic [2:0] src_rise;
  logic bypass, div_edge, div_mclk, div_tick, tick;

  assign src_rise = sync2_ff & ~prev_ff;
  assign bypass = clksel_ff == adccfg_pkg::CLK_EXT;
  assign div_edge = (clksel_ff == adccfg_pkg::CLK_XTAL) ? src_rise[1] :
                    src_rise[0];
  assign tick = bypass ? src_rise[2] : div_tick;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      sync1_ff <= {crystal_or_clock_io_pin_in, crystal_input_pin_in,
                   osc_clk_in};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  adccfg_mclk_div #(
    .DIV(adccfg_pkg::MCLK_DIV)
  ) u_div (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .edge_in(div_edge),
    .mclk_out(div_mclk),
    .tick_out(div_tick)
  );

  // Conversion sequencing
  logic conv;
  logic [15:0] eff_en;
  logic [23:0] code;
  logic [3:0] nxt_cur;

  assign conv = tick & (tcnt_ff == 16'(CONV_TICKS - 1));
  assign eff_en = se_ff ? chen_ff : {8'h00, chen_ff[7:0]};
  assign nxt_cur = next_ch(cur_ff, eff_en);

  adccfg_coder u_coder (
    .sample_in(sample_in),
    .bipolar_in(bip_ff[cur_ff[2:0]]),
    .code_out(code)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tcnt_ff <= 16'h0000;
      cur_ff <= 4'h0;
      data_ff <= 24'h000000;
    end else if (conv) begin
      tcnt_ff <= 16'h0000;
      cur_ff <= nxt_cur;
      data_ff <= code;
    end else if (tick) begin
      tcnt_ff <= tcnt_ff + 16'h0001;
    end
  end

  // A new result wins over a read that clears the flag
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= conv | (ready_ff & ~(rd_acc & sel_data));
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mux_pos_ff <= 4'h0;
      mux_neg_ff <= 5'h01;
      active_ref_ff <= adccfg_pkg::REFSEL_RST;
      ref_drive_ff <= 1'b0;
      mclk_ff <= 1'b0;
      io_out_ff <= 1'b0;
      io_oe_b_ff <= 1'b1;
      conv_ff <= 1'b0;
    end else begin
      mux_pos_ff <= se_ff ? cur_ff : {cur_ff[2:0], 1'b0};
      mux_neg_ff <= se_ff ? adccfg_pkg::COMMON_IDX
                          : {1'b0, cur_ff[2:0], 1'b1};
      active_ref_ff <= refsel_ff[cur_ff[2:0]];
      ref_drive_ff <= ref_en_ff;
      mclk_ff <= bypass ? sync2_ff[2] : div_mclk;
      io_out_ff <= sync2_ff[0];
      io_oe_b_ff <= clksel_ff != adccfg_pkg::CLK_INT_OUT;
      conv_ff <= conv;
    end
  end

  assign avs_waitrequest_out = waitreq_ff;
  assign avs_readdata_out = rdata_ff;
  assign mux_pos_out = mux_pos_ff;
  assign mux_neg_out = mux_neg_ff;
  assign reference_source_select_out = active_ref_ff;
  assign reference_output_pin_en_out = ref_drive_ff;
  assign master_clock_out = mclk_ff;
  assign crystal_or_clock_io_pin_out = io_out_ff;
  assign crystal_or_clock_io_pin_oe_b_out = io_oe_b_ff;
  assign conv_done_out = conv_ff;

  // Helper: source edges seen between two divider ticks
  logic [3:0] ecnt_ff;
  logic seen_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ecnt_ff <= 4'h0;
      seen_ff <= 1'b0;
    end else if (wr_acc & sel_mode) begin
      ecnt_ff <= 4'h0;
      seen_ff <= 1'b0;
    end else if (div_tick) begin
      ecnt_ff <= 4'h0;
      seen_ff <= 1'b1;
    end else if (div_edge && ecnt_ff != 4'hF) begin
      ecnt_ff <= ecnt_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence bus_req_s;
    req && waitreq_ff;
  endsequence
  sequence bus_ack_s;
    !waitreq_ff ##1 waitreq_ff;
  endsequence
  sequence refen_wr_s;
    wr_acc && sel_mode && avs_writedata_in[adccfg_pkg::MODE_REFEN_BIT];
  endsequence

  bus_ack_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("bus access not acknowledged after one wait cycle");
  ref_drive_a: assert property (refen_wr_s |=> ##1 ref_drive_ff)
    else $error("reference pin not enabled after enable write");
  diff_pair_a: assert property (##1 !$past(se_ff) |->
    mux_neg_ff == {1'b0, mux_pos_ff} + 5'h01 && !mux_pos_ff[0])
    else $error("differential pair is not adjacent even/odd");
  se_common_a: assert property ($past(se_ff) |->
    mux_neg_ff == adccfg_pkg::COMMON_IDX)
    else $error("single-ended channel not paired with common input");
  clk_pin_a: assert property (
    (clksel_ff == adccfg_pkg::CLK_INT_OUT) [*2] |-> !io_oe_b_ff)
    else $error("oscillator clock not driven on shared pin");
  div_eight_a: assert property (div_tick && seen_ff |->
    ecnt_ff == 4'(adccfg_pkg::MCLK_DIV - 1))
    else $error("master clock period is not eight source edges");
  bip_zero_a: assert property (conv && bip_ff[cur_ff[2:0]] &&
    sample_in == 25'sh0 |=> data_ff == 24'h800000)
    else $error("bipolar zero input did not give midscale");
  uni_zero_a: assert property (conv && !bip_ff[cur_ff[2:0]] &&
    sample_in == 25'sh0 |=> data_ff == 24'h000000)
    else $error("unipolar zero input did not give zero code");
  seq_order_a: assert property (conv && cur_ff != 4'hF &&
    (eff_en >> (cur_ff + 4'h1)) != 0 |=> cur_ff > $past(cur_ff))
    else $error("sequencer did not move to a higher enabled channel");
endmodule : adccfg_top
`default_nettype wire

//--- pkg/adccfg_pkg.sv
`default_nettype none
package adccfg_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_MODE = 6'h00;
  localparam logic [5:0] OFF_CHEN = 6'h04;
  localparam logic [5:0] OFF_STAT = 6'h08;
  localparam logic [5:0] OFF_DATA = 6'h0C;
  localparam logic [5:0] OFF_SETUP = 6'h20;
  // Mode register fields
  localparam int MODE_REFEN_BIT = 15;
  localparam int MODE_SE_BIT = 8;
  localparam int MODE_CLKSEL_LSB = 2;
  // Setup register fields
  localparam int SETUP_REFSEL_LSB = 4;
  localparam int SETUP_BIP_BIT = 12;
  localparam int NUM_SETUPS = 8;
  // Status register fields
  localparam int STAT_RDY_BIT = 4;
  localparam int STAT_REF_LSB = 5;
  localparam int STAT_MCLK_BIT = 7;
  // Reset values
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  localparam logic [15:0] CHEN_RST = 16'h0001;
  localparam logic [1:0] REFSEL_RST = 2'h0;
  localparam logic SETUP_BIP_RST = 1'b1;
  // Reference sources
  localparam logic [1:0] REFSEL_EXT = 2'h0;
  localparam logic [1:0] REFSEL_INT = 2'h2;
  localparam logic [1:0] REFSEL_AVDD = 2'h3;
  // Master clock sources
  localparam logic [1:0] CLK_INT = 2'h0;
  localparam logic [1:0] CLK_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  localparam logic [1:0] CLK_XTAL = 2'h3;
  // Clock rates in MHz
  localparam int OSC_MHZ = 16;
  localparam int MCLK_MHZ = 2;
  localparam int MCLK_DIV = OSC_MHZ / MCLK_MHZ;
  // Conversion path
  localparam int CODE_W = 24;
  localparam int NUM_CH = 16;
  localparam logic [4:0] COMMON_IDX = 5'h10;
endpackage : adccfg_pkg
`default_nettype wire

//--- src/adccfg_mclk_div.sv
`default_nettype none
module adccfg_mclk_div #(
  parameter int DIV = adccfg_pkg::MCLK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Source edges in, divided clock out
  input wire logic edge_in,
  output logic mclk_out,
  output logic tick_out
);
  localparam int HALF = DIV / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_ff;
  logic mclk_ff;
  logic wrap;

  // Toggle every half period keeps the duty cycle at one half
  assign wrap = edge_in & (cnt_ff == LAST);
  assign tick_out = wrap & ~mclk_ff;
  assign mclk_out = mclk_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
      mclk_ff <= 1'b0;
    end else if (wrap) begin
      cnt_ff <= '0;
      mclk_ff <= ~mclk_ff;
    end else if (edge_in) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end
endmodule : adccfg_mclk_div
`default_nettype wire

//--- src/adccfg_coder.sv
`default_nettype none
module adccfg_coder (
  // Scaled sample in, code out
  input wire logic signed [24:0] sample_in,
  input wire logic bipolar_in,
  output logic [adccfg_pkg::CODE_W-1:0] code_out
);
  localparam logic signed [25:0] HALF_SC = 26'sh0800000;
  localparam logic signed [25:0] FULL_SC = 26'sh0FFFFFF;

  logic signed [25:0] uni;
  logic signed [25:0] bip;
  logic signed [25:0] sel;

  // Sample is 2^24 * vin * 0.1 / vref
  assign uni = 26'(sample_in);
  assign bip = 26'(sample_in >>> 1) + HALF_SC;
  assign sel = bipolar_in ? bip : uni;
  // Out-of-range inputs saturate rather than wrap
  assign code_out = (sel < 0) ? '0 :
                    (sel > FULL_SC) ? '1 : sel[23:0];
endmodule : adccfg_coder
`default_nettype wire

//--- testbench/adccfg_clk_model.sv
`default_nettype none
module adccfg_clk_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Shared pin, device side
  input wire logic pin_drv_in,
  input wire logic pin_oe_b_in,
  // Clock sources
  output logic osc_out,
  output logic xtal_out,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_ff;
  logic ext_clk;
  // Sources kept slow so clk_in sees every level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= (cnt_ff == 5'h17) ? 5'h00 : cnt_ff + 5'h01;
    end
  end
  assign osc_out = (cnt_ff % 4) < 2;
  assign xtal_out = (cnt_ff % 6) < 3;
  assign ext_clk = (cnt_ff % 8) < 4;
  // Pin follows the device while it drives, else the outside clock
  assign pin_out = pin_oe_b_in ? ext_clk : pin_drv_in;
endmodule : adccfg_clk_model
`default_nettype wire

//--- testbench/test_adc_input_ref_clock_config.sv
`default_nettype none
module test_adc_input_ref_clock_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic osc, xtal, pin, pin_o, oe_b, master_clock_out;
  logic signed [24:0] sample_in = 25'h0;
  logic [3:0] mux_pos_out;
  logic [4:0] mux_neg_out;
  logic [1:0] ref_sel;
  logic ref_en, conv_done_out;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rs [3] = '{adccfg_pkg::REFSEL_EXT, adccfg_pkg::REFSEL_INT,
                         adccfg_pkg::REFSEL_AVDD};
  int per_x [4] = '{32, 32, 8, 48};
  int corner [4] = '{0, 8388608, -16777216, 16777215};

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  adccfg_clk_model src (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .pin_drv_in(pin_o), .pin_oe_b_in(oe_b), .osc_out(osc),
    .xtal_out(xtal), .pin_out(pin));

  adccfg_top #(.CONV_TICKS(2)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .osc_clk_in(osc), .crystal_input_pin_in(xtal),
    .crystal_or_clock_io_pin_in(pin), .crystal_or_clock_io_pin_out(pin_o),
    .crystal_or_clock_io_pin_oe_b_out(oe_b),
    .master_clock_out(master_clock_out), .sample_in(sample_in),
    .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out),
    .reference_source_select_out(ref_sel),
    .reference_output_pin_en_out(ref_en), .conv_done_out(conv_done_out));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Called just after a rising edge; holds until waitrequest samples low
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] wd);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // No local limit: only the watchdog ends a stuck access
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic meas(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (master_clock_out !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    while (master_clock_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    while (master_clock_out === 1'b1 && hi < 300) begin
      @(posedge clk_in);
      hi++;
    end
    per = hi;
    while (master_clock_out === 1'b0 && per < 300) begin
      @(posedge clk_in);
      per++;
    end
  endtask : meas

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (conv_done_out !== 1'b1 && n < 200);
    if (n >= 200) err_total++;
  endtask : wait_done

  function automatic int nxt_ch(int c, logic [15:0] en, int nch);
    for (int i = 1; i <= nch; i++) begin
      if (en[(c + i) % nch]) return (c + i) % nch;
    end
    return c;
  endfunction : nxt_ch

  function automatic logic [31:0] exp_code(int s, logic bip);
    int v;
    v = bip ? s / 2 + 8388608 : s;
    if (v < 0) v = 0;
    if (v > 16777215) v = 16777215;
    return 32'(v);
  endfunction : exp_code

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    end_sim();
  end

  initial begin
    int hi, per, ch, prev, t0, s, nch;
    logic se, bip;
    logic [15:0] en;
    void'($urandom(32'h83bcbc5a));
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    chk("ref_en", 32'h0, {31'h0, ref_en});
    chk("oe_b", 32'h1, {31'h0, oe_b});
    bus(1'b0, adccfg_pkg::OFF_MODE, 32'h0);
    chk("mode", 32'h0, rd);
    bus(1'b0, adccfg_pkg::OFF_SETUP, 32'h0);
    chk("setup0", 32'h1000, rd);
    bus(1'b1, 6'h10, 32'hFFFFFFFF);
    bus(1'b0, 6'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, adccfg_pkg::OFF_MODE, 32'h8000);
    repeat (2) @(posedge clk_in);
    chk("ref_en", 32'h1, {31'h0, ref_en});
    bus(1'b1, adccfg_pkg::OFF_MODE, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("ref_en", 32'h0, {31'h0, ref_en});
    $display("test reset and reference done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, adccfg_pkg::OFF_MODE, 32'(k) << 2);
      // Let the new source settle; the first measurement is discarded
      meas(hi, per);
      meas(hi, per);
      chk("mclk period", 32'(per_x[k]),
          32'(per));
      chk("mclk high", 32'(per_x[k] / 2), 32'(hi));
      chk("oe_b", {31'h0, k != 1}, {31'h0, oe_b});
      if (k == 1) begin
        hi = 0;
        for (int j = 0; j < 32; j++) begin
          @(posedge clk_in);
          hi += int'(pin_o);
        end
        chk("pin clock high", 32'h10, 32'(hi));
      end
    end
    // Mid-run reset must bring the clock select back to the oscillator
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, adccfg_pkg::OFF_MODE, 32'h0);
    chk("mode after reset", 32'h0, rd);
    $display("test clock select done");
    for (int r = 0; r < 4; r++) begin
      se = r[0];
      bip = r[1];
      nch = se ? 16 : 8;
      en = 16'($urandom()) & (se ? 16'hFFFF : 16'h00FF);
      if (en == 16'h0) en = 16'h0001;
      for (int i = 0; i < 8; i++)
        bus(1'b1, 6'(adccfg_pkg::OFF_SETUP + 4 * i),
            {19'h0, bip, 6'h0, rs[i % 3], 4'h0});
      bus(1'b1, adccfg_pkg::OFF_CHEN, {16'h0, en});
      bus(1'b1, adccfg_pkg::OFF_MODE,
          {23'h0, se, 4'h0, adccfg_pkg::CLK_EXT, 2'h0});
      s = corner[0];
      sample_in <= 25'(s);
      wait_done();
      for (int k = 0; k < 7; k++) begin
        wait_done();
        ch = se ? int'(mux_pos_out) : int'(mux_pos_out) / 2;
        chk("mux_neg",
            se ? 32'h10 : 32'(mux_pos_out) + 32'h1, {27'h0, mux_neg_out});
        chk("ref_sel", {30'h0, rs[(ch % 8) % 3]}, {30'h0, ref_sel});
        if (k > 0) begin
          chk("channel", 32'(nxt_ch(prev, en, nch)), 32'(ch));
          chk("conv gap", 32'h10, 32'(cyc - t0));
        end
        prev = ch;
        t0 = cyc;
        bus(1'b0, adccfg_pkg::OFF_DATA, 32'h0);
        chk("code", exp_code(s, bip),
            rd & 32'h00FFFFFF);
        s = (k < 3) ? corner[k + 1] :
            (int'($urandom_range(0, 33554431)) - 16777216) & ~1;
        sample_in <= 25'(s);
      end
    end
    $display("test conversion done");
    end_sim();
  end
endmodule : test_adc_input_ref_clock_config
`default_nettype wire
